// file: rtl/trap_aux_pkg.sv
// Package of constants and types for the feature-trap and auxiliary control registers
// Functional notes
// - EL2 trace-access trap bit 20 reads zero
// - EL2 trap register fields have no reset
// - Vector/float trap bit clear traps nothing; resets clear
// - Vector/float trap bit set traps use to EL3
// - Auxiliary registers are 64 bits, unbanked
// - Decode auxiliary registers at their system encodings
// - Auxiliary registers read and written by sysreg instructions
// - EL0 denied; secure EL1/EL3, non-secure EL1-3 allowed
// - Non-secure with trap-general set: EL2 and EL3
// - Secondary register writes from EL1/EL2 gated by enables
package trap_aux_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Encoding fields and register encodings {op0, op1, crn, crm, op2}
    localparam int ENC_W = 16;
    localparam logic [ENC_W-1:0] ENC_AUX_PRI = {2'h3, 3'h0, 4'hf, 4'h1, 3'h0};
    localparam logic [ENC_W-1:0] ENC_AUX_SEC = {2'h3, 3'h0, 4'hf, 4'h1, 3'h1};
    localparam logic [ENC_W-1:0] ENC_EL2_TRAP = {2'h3, 3'h4, 4'h1, 4'h1, 3'h2};
    localparam logic [ENC_W-1:0] ENC_EL3_TRAP = {2'h3, 3'h6, 4'h1, 4'h1, 3'h2};

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int TRACE_TRAP_POS = 20;
    localparam int FP_TRAP_POS = 10;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and masks
    localparam logic [63:0] AUX_RESET = 64'h0000_0000_0000_0000;
    localparam logic [31:0] EL3_TRAP_RESET = 32'h0000_0000;
    localparam logic [31:0] TRAP_WMASK = 32'hffef_ffff;

    ////////////////////////////////////////////////////////////////////////////
    // Exception levels
    localparam logic [1:0] EL0 = 2'h0;
    localparam logic [1:0] EL1 = 2'h1;
    localparam logic [1:0] EL2 = 2'h2;
    localparam logic [1:0] EL3 = 2'h3;

    // Decoded register target
    typedef enum logic [2:0] {
        TGT_NONE = 3'b000,
        TGT_AUX_PRI = 3'b001,
        TGT_AUX_SEC = 3'b010,
        TGT_EL2_TRAP = 3'b011,
        TGT_EL3_TRAP = 3'b100
    } target_type;

    // One system-register access request from the core
    typedef struct packed {
        logic valid;
        logic write;
        logic [ENC_W-1:0] enc;
        logic [63:0] wdata;
    } sysreg_req_type;

    // Current execution context of the core
    typedef struct packed {
        logic [1:0] el;
        logic security_world_bit;
        logic trap_general_bit;
        logic host_extension_bit;
    } exec_ctx_type;

    // Whole state of the register bank
    typedef struct packed {
        logic [63:0] aux_control_primary;
        logic [63:0] aux_control_secondary;
        logic [31:0] el2_feature_trap;
        logic [31:0] el3_feature_trap;
        logic resp_valid;
        logic resp_fault;
        logic [63:0] resp_rdata;
    } bank_state_type;

endpackage : trap_aux_pkg

// file: rtl/sysreg_access_check.sv
// Encoding decode and per-level access permission for the register bank
`timescale 1ns/1ns
module sysreg_access_check import trap_aux_pkg::*; (
    // Request and context
    input wire sysreg_req_type req,
    input wire exec_ctx_type ctx,
    // Auxiliary write enables, bit 0 of each enable register
    input wire logic el2_aux_enable_reg,
    input wire logic el3_aux_enable_reg,
    // Decode results
    output target_type tgt,
    output logic read_ok,
    output logic write_ok
);

    logic el_ok; // Level may touch the auxiliary registers
    logic sec_wr_ok; // Extra gate for the secondary register

    ////////////////////////////////////////////////////////////////////////////
    // Encoding decode
    always_comb begin
        case (req.enc)
            ENC_AUX_PRI: tgt = TGT_AUX_PRI;
            ENC_AUX_SEC: tgt = TGT_AUX_SEC;
            ENC_EL2_TRAP: tgt = TGT_EL2_TRAP;
            ENC_EL3_TRAP: tgt = TGT_EL3_TRAP;
            default: tgt = TGT_NONE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Permission table; the host-extension bit plays no part
    always_comb begin
        case (ctx.el)
            EL0: el_ok = 1'b0;
            // EL1 cannot run with non-secure and trap-general set
            EL1: el_ok = !(ctx.security_world_bit && ctx.trap_general_bit);
            EL2: el_ok = ctx.security_world_bit;
            EL3: el_ok = 1'b1;
            default: el_ok = 1'b0;
        endcase
        // Secure EL1 answers to the EL3 enable only
        case (ctx.el)
            EL1: sec_wr_ok = el3_aux_enable_reg
                && (el2_aux_enable_reg || !ctx.security_world_bit);
            EL2: sec_wr_ok = el3_aux_enable_reg;
            default: sec_wr_ok = 1'b1;
        endcase
        case (tgt)
            TGT_AUX_PRI: begin
                read_ok = el_ok;
                write_ok = el_ok;
            end
            TGT_AUX_SEC: begin
                read_ok = el_ok;
                write_ok = el_ok && sec_wr_ok;
            end
            TGT_EL2_TRAP: begin
                read_ok = (ctx.el == EL3) || (ctx.el == EL2 && ctx.security_world_bit);
                write_ok = read_ok;
            end
            TGT_EL3_TRAP: begin
                read_ok = (ctx.el == EL3);
                write_ok = read_ok;
            end
            default: begin
                read_ok = 1'b0;
                write_ok = 1'b0;
            end
        endcase
    end

endmodule : sysreg_access_check

// file: rtl/feature_trap_aux_ctrl_regs.sv
// Feature-trap and auxiliary control system registers of the core
`timescale 1ns/1ns
module feature_trap_aux_ctrl_regs import trap_aux_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // System-register access from the core
    input wire sysreg_req_type req,
    input wire exec_ctx_type ctx,
    input wire logic el2_aux_enable_reg,
    input wire logic el3_aux_enable_reg,
    // Access answer, one cycle after the request
    output logic resp_valid,
    output logic resp_fault,
    output logic [63:0] resp_rdata,
    // Vector and floating-point register use check
    input wire logic fp_use_valid,
    output logic fp_trap_el3,
    // Auxiliary control values to the core
    output logic [63:0] aux_control_primary,
    output logic [63:0] aux_control_secondary
);

    bank_state_type st_r; // Registered state
    bank_state_type st_nxt; // Next state
    target_type tgt; // Decoded target
    logic read_ok; // Read permitted
    logic write_ok; // Write permitted

    ////////////////////////////////////////////////////////////////////////////
    // Decode and permission
    sysreg_access_check u_check (
        .req(req),
        .ctx(ctx),
        .el2_aux_enable_reg(el2_aux_enable_reg),
        .el3_aux_enable_reg(el3_aux_enable_reg),
        .tgt(tgt),
        .read_ok(read_ok),
        .write_ok(write_ok)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        st_nxt = st_r;
        // Answer stands for one cycle only
        st_nxt.resp_valid = 1'b0;
        st_nxt.resp_fault = 1'b0;
        st_nxt.resp_rdata = 64'h0;
        if (req.valid) begin
            st_nxt.resp_valid = 1'b1;
            if (req.write) begin
                // Refused write leaves every register untouched
                if (!write_ok) begin
                    st_nxt.resp_fault = 1'b1;
                end else begin
                    case (tgt)
                        TGT_AUX_PRI: st_nxt.aux_control_primary = req.wdata;
                        TGT_AUX_SEC: st_nxt.aux_control_secondary = req.wdata;
                        // Trace-access bit is not built; writes to it drop
                        TGT_EL2_TRAP: st_nxt.el2_feature_trap = req.wdata[31:0] & TRAP_WMASK;
                        TGT_EL3_TRAP: st_nxt.el3_feature_trap = req.wdata[31:0] & TRAP_WMASK;
                        default: st_nxt.resp_fault = 1'b1;
                    endcase
                end
            end else begin
                if (!read_ok) begin
                    st_nxt.resp_fault = 1'b1;
                end else begin
                    case (tgt)
                        TGT_AUX_PRI: st_nxt.resp_rdata = st_r.aux_control_primary;
                        TGT_AUX_SEC: st_nxt.resp_rdata = st_r.aux_control_secondary;
                        // Mask again: the register may still hold unknowns from reset
                        TGT_EL2_TRAP: st_nxt.resp_rdata =
                            {32'h0, st_r.el2_feature_trap & TRAP_WMASK};
                        TGT_EL3_TRAP: st_nxt.resp_rdata = {32'h0, st_r.el3_feature_trap};
                        default: st_nxt.resp_fault = 1'b1;
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; EL2 trap fields deliberately keep no reset value
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_r.aux_control_primary <= AUX_RESET;
            st_r.aux_control_secondary <= AUX_RESET;
            st_r.el3_feature_trap <= EL3_TRAP_RESET;
            st_r.resp_valid <= 1'b0;
            st_r.resp_fault <= 1'b0;
            st_r.resp_rdata <= 64'h0;
            // el2_feature_trap is left as it was: software must program it
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign resp_valid = st_r.resp_valid;
    assign resp_fault = st_r.resp_fault;
    assign resp_rdata = st_r.resp_rdata;
    // One shared copy serves both security states
    assign aux_control_primary = st_r.aux_control_primary;
    assign aux_control_secondary = st_r.aux_control_secondary;
    // Trap at any level or state; priority against other exceptions is the core's
    assign fp_trap_el3 = fp_use_valid && st_r.el3_feature_trap[FP_TRAP_POS];

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    // Read request to a given target
    sequence s_read_req(target_type t);
        req.valid && !req.write && tgt == t;
    endsequence

    // Write request to a given target
    sequence s_write_req(target_type t);
        req.valid && req.write && tgt == t;
    endsequence

    // Faulting answer in the next cycle
    sequence s_fault_next;
        ##1 (resp_valid && resp_fault);
    endsequence

    // EL2 trap reads never show the trace bit
    trace_bit_zero_a: assert property (@(posedge clk) disable iff (!resetn)
        s_read_req(TGT_EL2_TRAP) ##0 read_ok |=> !resp_rdata[TRACE_TRAP_POS])
        else $error("trace trap bit read as one");

    // Vector trap bit cleared by reset
    fp_trap_reset_a: assert property (@(posedge clk)
        !$past(resetn) |-> !st_r.el3_feature_trap[FP_TRAP_POS])
        else $error("vector trap bit not clear after reset");

    // Trap bit written set: any register use traps to EL3
    fp_trap_set_a: assert property (@(posedge clk) disable iff (!resetn)
        s_write_req(TGT_EL3_TRAP) ##0 write_ok ##0 req.wdata[FP_TRAP_POS]
        |=> fp_trap_el3 == fp_use_valid)
        else $error("vector trap not raised with bit set");

    // Trap bit written clear: nothing traps
    fp_trap_clear_a: assert property (@(posedge clk) disable iff (!resetn)
        s_write_req(TGT_EL3_TRAP) ##0 write_ok ##0 !req.wdata[FP_TRAP_POS]
        |=> !fp_trap_el3)
        else $error("vector trap raised with bit clear");

    // Permitted write to primary is stored exactly
    aux_store_a: assert property (@(posedge clk) disable iff (!resetn)
        s_write_req(TGT_AUX_PRI) ##0 write_ok
        |=> aux_control_primary == $past(req.wdata) && resp_valid && !resp_fault)
        else $error("primary auxiliary write lost");

    // Permitted read returns stored secondary value
    aux_readback_a: assert property (@(posedge clk) disable iff (!resetn)
        s_read_req(TGT_AUX_SEC) ##0 read_ok
        |=> resp_valid && !resp_fault && resp_rdata == $past(aux_control_secondary))
        else $error("secondary auxiliary read mismatch");

    // EL0 never reaches the auxiliary registers
    el0_deny_a: assert property (@(posedge clk) disable iff (!resetn)
        req.valid && ctx.el == EL0 && (tgt == TGT_AUX_PRI || tgt == TGT_AUX_SEC)
        |-> s_fault_next)
        else $error("EL0 access not refused");

    // EL2 allowed with non-secure and trap-general set
    tge_el2_allow_a: assert property (@(posedge clk) disable iff (!resetn)
        s_read_req(TGT_AUX_PRI) ##0 (ctx.el == EL2 && ctx.security_world_bit
        && ctx.trap_general_bit) |=> resp_valid && !resp_fault)
        else $error("EL2 access refused with trap-general set");

    // Secure EL2 has no access
    sec_el2_deny_a: assert property (@(posedge clk) disable iff (!resetn)
        s_write_req(TGT_AUX_PRI) ##0 (ctx.el == EL2 && !ctx.security_world_bit)
        |-> s_fault_next)
        else $error("secure EL2 access not refused");

    // Secondary write gated by the EL3 enable
    sec_write_gate_a: assert property (@(posedge clk) disable iff (!resetn)
        s_write_req(TGT_AUX_SEC) ##0 ((ctx.el == EL1 || ctx.el == EL2)
        && !el3_aux_enable_reg)
        |=> resp_fault && aux_control_secondary == $past(aux_control_secondary))
        else $error("gated secondary write took effect");

    // Secondary encoding decodes to the secondary register
    decode_enc_a: assert property (@(posedge clk) disable iff (!resetn)
        (req.enc == {2'h3, 3'h0, 4'hf, 4'h1, 3'h1}) |-> tgt == TGT_AUX_SEC)
        else $error("secondary encoding not decoded");

    // Unmapped encodings are refused
    unmapped_fault_a: assert property (@(posedge clk) disable iff (!resetn)
        req.valid && tgt == TGT_NONE |-> s_fault_next)
        else $error("unmapped encoding answered");

    // Trace bit of the EL2 trap register is never stored
    trace_bit_drop_a: assert property (@(posedge clk) disable iff (!resetn)
        s_write_req(TGT_EL2_TRAP) ##0 write_ok |=> !st_r.el2_feature_trap[TRACE_TRAP_POS])
        else $error("trace trap bit stored");

    // Every request answered in the next cycle
    resp_follow_a: assert property (@(posedge clk) disable iff (!resetn)
        req.valid |=> resp_valid)
        else $error("request left unanswered");

    // No answer without a request
    resp_spur_a: assert property (@(posedge clk) disable iff (!resetn)
        !req.valid |=> !resp_valid)
        else $error("answer without request");

    // Writes return zero read data
    wr_rdata_zero_a: assert property (@(posedge clk) disable iff (!resetn)
        req.valid && req.write |=> resp_rdata == 64'h0)
        else $error("write returned read data");

    // Permitted secondary write is stored exactly
    sec_store_a: assert property (@(posedge clk) disable iff (!resetn)
        s_write_req(TGT_AUX_SEC) ##0 write_ok
        |=> aux_control_secondary == $past(req.wdata) && !resp_fault)
        else $error("secondary auxiliary write lost");

    // EL3 writes to the secondary register are never gated
    sec_el3_open_a: assert property (@(posedge clk) disable iff (!resetn)
        s_write_req(TGT_AUX_SEC) ##0 ctx.el == EL3 |=> resp_valid && !resp_fault)
        else $error("EL3 secondary write refused");

    // Permitted read returns stored primary value
    pri_readback_a: assert property (@(posedge clk) disable iff (!resetn)
        s_read_req(TGT_AUX_PRI) ##0 read_ok
        |=> resp_valid && !resp_fault && resp_rdata == $past(aux_control_primary))
        else $error("primary auxiliary read mismatch");

    // Non-secure EL1 with trap-general set is refused
    tge_el1_deny_a: assert property (@(posedge clk) disable iff (!resetn)
        s_read_req(TGT_AUX_PRI) ##0 (ctx.el == EL1 && ctx.security_world_bit
        && ctx.trap_general_bit) |-> s_fault_next)
        else $error("EL1 access taken with trap-general set");

endmodule : feature_trap_aux_ctrl_regs

// file: tb/tb.sv
// Self-checking bench for the feature-trap and auxiliary control registers
`timescale 1ns/1ns
module tb import trap_aux_pkg::*; ;

    ////////////////////////////////////////////////////////////
    // Design connections
    logic clk; // Core clock
    logic resetn; // Synchronous reset, active low
    sysreg_req_type req; // Access request
    exec_ctx_type ctx; // Execution context
    logic el2_en; // Enable bit 0 of the EL2 enable register
    logic el3_en; // Enable bit 0 of the EL3 enable register
    logic fp_use_valid; // Vector or float register use
    logic resp_valid;
    logic resp_fault;
    logic [63:0] resp_rdata;
    logic fp_trap_el3;
    logic [63:0] pri_out;
    logic [63:0] sec_out;
    // Shadow copies of the stored registers
    logic [63:0] pri_m;
    logic [63:0] sec_m;
    logic [31:0] el2_m;
    logic [31:0] el3_m;
    int fail_count;
    int comparisons;
    int seed_v;
    // Mapped encodings, then one unmapped neighbour
    logic [ENC_W-1:0] enc_tab [5] = '{ENC_AUX_PRI, ENC_AUX_SEC, ENC_EL2_TRAP, ENC_EL3_TRAP,
        16'hc78a};

    feature_trap_aux_ctrl_regs u_dut (
        .clk(clk), .resetn(resetn), .req(req), .ctx(ctx),
        .el2_aux_enable_reg(el2_en), .el3_aux_enable_reg(el3_en),
        .resp_valid(resp_valid), .resp_fault(resp_fault), .resp_rdata(resp_rdata),
        .fp_use_valid(fp_use_valid), .fp_trap_el3(fp_trap_el3),
        .aux_control_primary(pri_out), .aux_control_secondary(sec_out)
    );

    // Free-running 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////
    // Checking and expectation helpers
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Auxiliary access by level and world; EL1 cannot run with both bits set
    function automatic logic aux_ok(input exec_ctx_type c);
        case (c.el)
            EL1: return !(c.security_world_bit && c.trap_general_bit);
            EL2: return c.security_world_bit;
            EL3: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : aux_ok

    // Secondary write gate from the two enable bits
    function automatic logic sec_wr_ok(input exec_ctx_type c, input logic e2, input logic e3);
        case (c.el)
            EL1: return e3 && (e2 || !c.security_world_bit);
            EL2: return e3;
            default: return 1'b1;
        endcase
    endfunction : sec_wr_ok

    task automatic set_ctx(input logic [1:0] el, input logic world, input logic trap_gen);
        ctx.el = el;
        ctx.security_world_bit = world;
        ctx.trap_general_bit = trap_gen;
        ctx.host_extension_bit = 1'($urandom); // Ignored by the block
    endtask : set_ctx

    // One access, entered at a falling edge; answer checked one cycle on
    // Valid stays up afterwards so a following call never re-drives it in one step
    task automatic access(input logic wr, input logic [ENC_W-1:0] enc, input logic [63:0] wd);
        logic ok;
        logic [63:0] rd;
        logic [31:0] tw;
        ok = 1'b0;
        rd = '0;
        tw = wd[31:0] & ~(32'h1 << TRACE_TRAP_POS);
        case (enc)
            ENC_AUX_PRI: begin
                ok = aux_ok(ctx);
                rd = pri_m;
            end
            ENC_AUX_SEC: begin
                ok = aux_ok(ctx) && (!wr || sec_wr_ok(ctx, el2_en, el3_en));
                rd = sec_m;
            end
            ENC_EL2_TRAP: begin
                ok = (ctx.el == EL3) || (ctx.el == EL2 && ctx.security_world_bit);
                rd = {32'h0, el2_m};
            end
            ENC_EL3_TRAP: begin
                ok = (ctx.el == EL3);
                rd = {32'h0, el3_m};
            end
            default: ok = 1'b0;
        endcase
        req.valid = 1'b1;
        req.write = wr;
        req.enc = enc;
        req.wdata = wd;
        @(negedge clk);
        if (ok && wr) begin
            case (enc)
                ENC_AUX_PRI: pri_m = wd;
                ENC_AUX_SEC: sec_m = wd;
                ENC_EL2_TRAP: el2_m = tw;
                default: el3_m = tw;
            endcase
        end
        check(resp_valid, 64'h1);
        check(resp_fault, !ok);
        check(resp_rdata, (ok && !wr) ? rd : 64'h0);
        check(pri_out, pri_m);
        check(sec_out, sec_m);
        check(fp_trap_el3, fp_use_valid & el3_m[FP_TRAP_POS]);
    endtask : access

    // Reset for n cycles; shadows follow the documented reset values
    task automatic do_reset(input int n);
        req.valid = 1'b0;
        resetn = 1'b0;
        repeat (n) @(negedge clk);
        resetn = 1'b1;
        pri_m = '0;
        sec_m = '0;
        el3_m = '0;
    endtask : do_reset

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    ////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        resetn = 1'b0;
        req = '0;
        ctx = '0;
        el2_en = 1'b0;
        el3_en = 1'b0;
        fp_use_valid = 1'b1;
        fail_count = 0;
        comparisons = 0;
        seed_v = $urandom(21);
        @(negedge clk);
        do_reset(16);
        // Reset values seen from EL3, with register use pending
        set_ctx(EL3, 1'b0, 1'b0);
        access(1'b0, ENC_AUX_PRI, 64'h0);
        access(1'b0, ENC_AUX_SEC, 64'h0);
        access(1'b0, ENC_EL3_TRAP, 64'h0);
        // All ones into the trap registers; trace bit must stay clear
        access(1'b1, ENC_EL2_TRAP, '1);
        access(1'b0, ENC_EL2_TRAP, 64'h0);
        access(1'b1, ENC_EL3_TRAP, '1);
        access(1'b0, ENC_EL3_TRAP, 64'h0);
        access(1'b1, ENC_EL3_TRAP, 64'h0);
        // One idle cycle: no request, no answer
        req.valid = 1'b0;
        @(negedge clk);
        check(resp_valid, 64'h0);
        // Every register refused from EL0, read and write
        set_ctx(EL0, 1'b1, 1'b0);
        for (int i = 0; i < 10; i++) begin
            access(1'(i), enc_tab[i / 2], {$urandom, $urandom});
        end
        // Secondary write gate over level, world and both enables
        for (int g = 0; g < 16; g++) begin
            set_ctx(g[3] ? EL2 : EL1, g[2], 1'b0);
            el2_en = g[1];
            el3_en = g[0];
            access(1'b1, ENC_AUX_SEC, {$urandom, $urandom});
            access(1'b0, ENC_AUX_SEC, 64'h0);
        end
        // Random traffic, back to back, one access at a time as software would
        for (int n = 0; n < 300; n++) begin
            set_ctx(2'($urandom), 1'($urandom), 1'($urandom));
            el2_en = 1'($urandom);
            el3_en = 1'($urandom);
            fp_use_valid = 1'($urandom);
            access(1'($urandom), enc_tab[$urandom_range(4)], {$urandom, $urandom});
        end
        // Second reset in mid-run clears auxiliary and EL3 trap state
        do_reset(2);
        set_ctx(EL3, 1'b1, 1'b1);
        fp_use_valid = 1'b1;
        access(1'b0, ENC_AUX_PRI, 64'h0);
        access(1'b0, ENC_AUX_SEC, 64'h0);
        access(1'b0, ENC_EL3_TRAP, 64'h0);
        end_of_test();
    end

    // Watchdog well beyond the roughly 370 cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        $display("Error at %0t: watchdog expired", $time);
        end_of_test();
    end

endmodule : tb
